// [core/spc_pkg.sv]
// spc_pkg: constants and types of the spi configuration and status register
package spc_pkg;

	// ------------------------------------------------------------
	// register address and reset image
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'ha1;
	localparam logic [7:0] REG_RESET = 8'h07;

	// ------------------------------------------------------------
	// bit positions inside spi_configuration
	// ------------------------------------------------------------
	localparam int BIT_BUSY = 7;
	localparam int BIT_MASTER = 6;
	localparam int BIT_PHASE = 5;
	localparam int BIT_IDLE = 4;
	localparam int BIT_SELECTED = 3;
	localparam int BIT_RAW = 2;
	localparam int BIT_SHIFTER_EMPTY = 1;
	localparam int BIT_RXE = 0;

	// ------------------------------------------------------------
	// select wiring modes and link counts
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
	localparam logic [1:0] MODE_FOUR_WIRE_IN = 2'h1;
	localparam int MODE_OUT_BIT = 1;
	localparam int MODE_LEVEL_BIT = 0;
	localparam int BYTE_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int SYNC_MIN = 3;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic master_select;
		logic clock_phase_sel;
		logic clock_idle_level;
	} spc_cfg_t;

	typedef struct packed {
		logic valid;
		logic [BYTE_W-1:0] data;
	} spc_byte_t;

	localparam spc_cfg_t CFG_RESET = '{
		master_select: REG_RESET[BIT_MASTER],
		clock_phase_sel: REG_RESET[BIT_PHASE],
		clock_idle_level: REG_RESET[BIT_IDLE]
	};

endpackage

// [core/spc_config_status.sv]
// spc_config_status: spi configuration and status register with slave link front end
`timescale 1ns/10ps
`default_nettype none

module spc_config_status #(
	parameter int SYNC_STAGES = 3
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// from control register and shifting engine
	input wire logic port_enable,
	input wire logic [1:0] select_mode_field,
	input wire logic master_busy,
	input wire logic tx_load,
	input wire logic tx_buf_empty,
	// configuration and status to the engine
	output spc_pkg::spc_cfg_t cfg,
	output logic transfer_in_progress,
	output logic shifter_empty,
	output logic rx_holding_empty,
	// received bytes
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_overrun,
	// link pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic slave_select_n_i,
	output logic slave_select_n_o,
	output logic slave_select_n_oe_n
);

	if (SYNC_STAGES < spc_pkg::SYNC_MIN) begin : g_bad_sync
		$error("SYNC_STAGES must be at least three");
	end

	// ------------------------------------------------------------
	// link domain: shifter on the sampling edge of sck
	// ------------------------------------------------------------
	logic sample_inv;
	logic samp_clk;
	logic link_rst;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] link_hold;
	logic bit_tgl;
	logic byte_tgl;

	// sampling edge: rising when idle level equals phase, else falling
	assign sample_inv = cfg.clock_idle_level ^ cfg.clock_phase_sel;
	assign samp_clk = sck ^ sample_inv;
	// counter held clear while port disabled or deselected in four-wire input mode, released on the falling select edge
	assign link_rst = sys_rst | ~port_enable
		| ((select_mode_field == spc_pkg::MODE_FOUR_WIRE_IN) & slave_select_n_i);

	always_ff @(posedge samp_clk or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
		end else begin
			shreg <= {shreg[6:0], mosi};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	always_ff @(posedge samp_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_tgl <= 1'b0;
			byte_tgl <= 1'b0;
			link_hold <= 8'h00;
		end else begin
			bit_tgl <= ~bit_tgl;
			if (!link_rst && bit_cnt == spc_pkg::LAST_BIT) begin
				byte_tgl <= ~byte_tgl;
				link_hold <= {shreg[6:0], mosi};
			end
		end
	end

	// ------------------------------------------------------------
	// crossing: select pin and link toggles into clk
	// ------------------------------------------------------------
	localparam int NSYNC = 3;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] filt;
	logic [NSYNC-1:0] filt_q;
	logic [SYNC_STAGES-1:0] chain [NSYNC];

	assign async_in = {byte_tgl, bit_tgl, slave_select_n_i};

	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				chain[i] <= {SYNC_STAGES{1'(i == 0)}}; // idle: select high, toggles low
				filt[i] <= 1'(i == 0);
				filt_q[i] <= 1'(i == 0);
			end else if (clk_en) begin
				chain[i] <= {chain[i][SYNC_STAGES-2:0], async_in[i]};
				if (chain[i][SYNC_STAGES-1] == chain[i][SYNC_STAGES-2]) begin
					filt[i] <= chain[i][SYNC_STAGES-1];
				end
				filt_q[i] <= filt[i];
			end
		end
	end

	logic ss_filt;
	logic bit_evt;
	logic byte_evt;
	assign ss_filt = filt[0];
	assign bit_evt = filt[1] ^ filt_q[1];
	assign byte_evt = filt[2] ^ filt_q[2];

	// ------------------------------------------------------------
	// configuration register writes
	// ------------------------------------------------------------
	logic wr_hit;
	logic rd_hit;
	assign wr_hit = sfr_wr && (sfr_addr == spc_pkg::ADDR_CFG);
	assign rd_hit = sfr_rd && (sfr_addr == spc_pkg::ADDR_CFG);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg <= spc_pkg::CFG_RESET;
		end else if (clk_en && wr_hit) begin
			cfg.master_select <= sfr_wdata[spc_pkg::BIT_MASTER];
			cfg.clock_phase_sel <= sfr_wdata[spc_pkg::BIT_PHASE];
			cfg.clock_idle_level <= sfr_wdata[spc_pkg::BIT_IDLE];
		end
	end

	// ------------------------------------------------------------
	// received byte staging and two-entry buffer
	// ------------------------------------------------------------
	spc_pkg::spc_byte_t pend;
	spc_pkg::spc_byte_t spare;
	logic in_ready;
	logic push;
	logic pop;
	assign in_ready = ~spare.valid;
	assign push = pend.valid & in_ready;
	assign pop = rx_valid & rx_ready;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend <= '0;
			rx_overrun <= 1'b0;
		end else if (clk_en) begin
			rx_overrun <= 1'b0;
			if (byte_evt && !cfg.master_select) begin
				if (pend.valid && !push) begin
					rx_overrun <= 1'b1;
				end else begin
					pend.valid <= 1'b1;
					pend.data <= link_hold;
				end
			end else if (push) begin
				pend.valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			spare <= '0;
		end else if (clk_en) begin
			if (pop) begin
				if (spare.valid) begin
					rx_data <= spare.data;
					spare.valid <= 1'b0;
				end else if (push) begin
					rx_data <= pend.data;
				end else begin
					rx_valid <= 1'b0;
				end
			end else if (push) begin
				if (!rx_valid) begin
					rx_data <= pend.data;
					rx_valid <= 1'b1;
				end else begin
					spare <= pend;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	logic four_wire;
	logic byte_done_idle;
	assign four_wire = (select_mode_field == spc_pkg::MODE_FOUR_WIRE_IN);
	assign byte_done_idle = byte_evt && tx_buf_empty && in_ready && !pend.valid;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			transfer_in_progress <= spc_pkg::REG_RESET[spc_pkg::BIT_BUSY];
		end else if (clk_en) begin
			if (cfg.master_select) begin
				transfer_in_progress <= master_busy;
			end else if (byte_evt || (four_wire && ss_filt) || !port_enable) begin
				transfer_in_progress <= 1'b0;
			end else if (bit_evt) begin
				transfer_in_progress <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shifter_empty <= spc_pkg::REG_RESET[spc_pkg::BIT_SHIFTER_EMPTY];
		end else if (clk_en) begin
			if (cfg.master_select) begin
				shifter_empty <= 1'b1;
			end else if (byte_done_idle) begin
				shifter_empty <= 1'b1;
			end else if (tx_load || bit_evt) begin
				shifter_empty <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_holding_empty <= spc_pkg::REG_RESET[spc_pkg::BIT_RXE];
		end else if (clk_en) begin
			rx_holding_empty <= cfg.master_select | ~rx_valid;
		end
	end

	// ------------------------------------------------------------
	// select pin drive and register read
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slave_select_n_o <= 1'b1;
			slave_select_n_oe_n <= 1'b1;
		end else if (clk_en) begin
			slave_select_n_o <= select_mode_field[spc_pkg::MODE_LEVEL_BIT];
			slave_select_n_oe_n <= ~select_mode_field[spc_pkg::MODE_OUT_BIT];
		end
	end

	logic [7:0] image;
	always_comb begin
		image = 8'h00;
		image[spc_pkg::BIT_BUSY] = transfer_in_progress;
		image[spc_pkg::BIT_MASTER] = cfg.master_select;
		image[spc_pkg::BIT_PHASE] = cfg.clock_phase_sel;
		image[spc_pkg::BIT_IDLE] = cfg.clock_idle_level;
		image[spc_pkg::BIT_SELECTED] = ~ss_filt;
		image[spc_pkg::BIT_RAW] = slave_select_n_i;
		image[spc_pkg::BIT_SHIFTER_EMPTY] = shifter_empty;
		image[spc_pkg::BIT_RXE] = rx_holding_empty;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfr_rdata <= 8'h00;
		end else if (clk_en) begin
			sfr_rdata <= rd_hit ? image : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !clk_en);

	sequence s_pin_low;
		(!slave_select_n_i && clk_en) [*7];
	endsequence
	sequence s_cfg_write;
		wr_hit ##1 1'b1;
	endsequence

	a_busy_master: assert property (cfg.master_select |=>
		transfer_in_progress == $past(master_busy))
		else $error("busy bit does not follow master engine");
	a_cfg_written: assert property (clk_en && wr_hit |=>
		cfg.master_select == $past(sfr_wdata[spc_pkg::BIT_MASTER])
		&& cfg.clock_idle_level == $past(sfr_wdata[spc_pkg::BIT_IDLE]))
		else $error("configuration write not stored");
	a_cfg_readonly: assert property ($changed(cfg) |-> $past(wr_hit))
		else $error("configuration changed without a write");
	a_sel_filtered: assert property (s_pin_low |-> image[spc_pkg::BIT_SELECTED])
		else $error("selected flag not set after stable low select");
	a_raw_read: assert property (rd_hit |=>
		sfr_rdata[spc_pkg::BIT_RAW] == $past(slave_select_n_i))
		else $error("raw select bit wrong on read");
	a_shifter_empty_master: assert property (cfg.master_select |=> shifter_empty)
		else $error("shifter empty not one in master mode");
	a_shifter_empty_load: assert property (!cfg.master_select && tx_load && !byte_done_idle
		&& !$past(wr_hit) |=> !shifter_empty)
		else $error("shifter empty not cleared by load");
	a_rxe_state: assert property (1'b1 |=>
		rx_holding_empty == ($past(cfg.master_select) || !$past(rx_valid)))
		else $error("receive empty does not track buffer");
	a_rxe_master: assert property (s_cfg_write and (cfg.master_select [*2]) |->
		rx_holding_empty)
		else $error("receive empty not one in master mode");
	a_sel_drive: assert property (select_mode_field[spc_pkg::MODE_OUT_BIT] |=>
		!slave_select_n_oe_n
		&& slave_select_n_o == $past(select_mode_field[spc_pkg::MODE_LEVEL_BIT]))
		else $error("select pin not driven in output mode");
	a_deselect_idle: assert property (!cfg.master_select && four_wire && ss_filt
		&& !$past(wr_hit) |=> !transfer_in_progress)
		else $error("slave busy while deselected");

endmodule // spc_config_status
`default_nettype wire

// [sim/spc_link_model.sv]
// spc_link_model: behavioural external spi master driving the link pins
`timescale 1ns/10ps
`default_nettype none

module spc_link_model (
	// link pins
	output var logic sck,
	output var logic mosi,
	output var logic sel_n
);
	// ----
	// idle pins, select released to its pull-up
	// ----
	initial begin
		sck = 1'b0;
		mosi = 1'b1;
		sel_n = 1'b1;
	end

	task automatic set_select(input logic lv);
		sel_n = lv;
	endtask

	// ----
	// one framed byte, msb first, 160 ns bit period
	// ----
	task automatic send_byte(input logic [7:0] b, input logic pha, input logic pol);
		sck = pol;
		#100; // idle level settles while still deselected
		sel_n = 1'b0;
		#500;
		for (int i = 7; i >= 0; i--) begin
			if (pha) begin
				sck = ~pol;
			end
			mosi = b[i];
			#80 sck = ~sck;
			#80 sck = pol;
		end
		#200 mosi = ~mosi;
		sel_n = 1'b1;
		#300;
	endtask
endmodule // spc_link_model
`default_nettype wire

// [sim/tb.sv]
// tb: self-checking bench for the spi configuration and status register
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfr_addr = 8'ha1;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic port_enable = 1'b1;
	logic [1:0] select_mode_field = 2'h1;
	logic master_busy = 1'b0;
	logic tx_load = 1'b0;
	logic tx_buf_empty = 1'b1;
	logic rx_ready = 1'b0;
	spc_pkg::spc_cfg_t cfg;
	logic [7:0] sfr_rdata, rx_data;
	logic transfer_in_progress, shifter_empty, rx_holding_empty, rx_valid, rx_overrun;
	logic sck, mosi, sel_n_m, sel_n_o, sel_n_oe_n, sel_n_w;
	logic clk_en = 1'b1;
	int ovr_cnt = 0;
	int n_mismatch = 0;
	int compares = 0;

	always #50 clk = ~clk;
	assign sel_n_w = sel_n_oe_n ? sel_n_m : sel_n_o;
	always @(posedge clk) begin
		if (rx_overrun === 1'b1) begin
			ovr_cnt <= ovr_cnt + 1;
		end
	end

	spc_config_status #(.SYNC_STAGES(3)) spc_config_status_inst (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .port_enable(port_enable),
		.select_mode_field(select_mode_field), .master_busy(master_busy),
		.tx_load(tx_load), .tx_buf_empty(tx_buf_empty), .cfg(cfg),
		.transfer_in_progress(transfer_in_progress), .shifter_empty(shifter_empty),
		.rx_holding_empty(rx_holding_empty), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_overrun(rx_overrun), .sck(sck), .mosi(mosi),
		.slave_select_n_i(sel_n_w), .slave_select_n_o(sel_n_o),
		.slave_select_n_oe_n(sel_n_oe_n));

	spc_link_model spc_link_model_inst (.sck(sck), .mosi(mosi), .sel_n(sel_n_m));

	// ----
	// helpers
	// ----
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(negedge clk);
		d = sfr_rdata;
	endtask

	task automatic rchk(input string nm, input logic [7:0] exp);
		logic [7:0] d;
		rd(8'ha1, d);
		chk(nm, d, exp);
	endtask

	task automatic wait_rx();
		int i;
		@(negedge clk);
		for (i = 0; i < 80 && rx_valid !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk("rx_valid", {7'h0, rx_valid}, 8'h01);
	endtask

	task automatic pop();
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask

	task automatic finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs();
		logic [7:0] d;
		rchk("reset image", 8'h07);
		wr(8'ha1, 8'hff);
		rchk("write all ones", 8'h77);
		chk("cfg", {5'h0, cfg}, 8'h07);
		master_busy <= 1'b1;
		rchk("master busy", 8'hf7);
		master_busy <= 1'b0;
		wr(8'ha2, 8'h00);
		rd(8'ha2, d);
		chk("unmapped read", d, 8'h00);
		rchk("unmapped write", 8'h77);
		wr(8'ha1, 8'h40);
		spc_link_model_inst.send_byte(8'h5a, 1'b0, 1'b0);
		repeat (8) @(negedge clk);
		rchk("master rx empty", 8'h47);
		wr(8'ha1, 8'h00);
		clk_en <= 1'b0;
		wr(8'ha1, 8'h40);
		clk_en <= 1'b1;
		@(negedge clk);
		chk("frozen write", {5'h0, cfg}, 8'h00);
	endtask

	task automatic t_select();
		spc_link_model_inst.set_select(1'b0);
		repeat (8) @(negedge clk);
		rchk("selected", 8'h0b);
		spc_link_model_inst.set_select(1'b1);
		rchk("raw before filter", 8'h0f);
		repeat (8) @(negedge clk);
		rchk("deselected", 8'h07);
	endtask

	task automatic t_modes();
		logic [7:0] bytes [4] = '{8'ha5, 8'h3c, 8'h81, 8'h5e};
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			port_enable <= 1'b0;
			wr(8'ha1, {2'h0, m[1], m[0], 4'h0});
			port_enable <= 1'b1;
			spc_link_model_inst.send_byte(bytes[m], m[1], m[0]);
			wait_rx();
			chk("rx byte", rx_data, bytes[m]);
			repeat (2) @(negedge clk);
			rchk("rx unread", {2'h0, m[1], m[0], 4'h6});
			pop();
			repeat (3) @(negedge clk);
			chk("rx read", {7'h0, rx_holding_empty}, 8'h01);
		end
		wr(8'ha1, 8'h00);
	endtask

	task automatic t_buffer();
		logic [7:0] bytes [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
		int base;
		base = ovr_cnt;
		for (int i = 0; i < 4; i++) begin
			spc_link_model_inst.send_byte(bytes[i], 1'b0, 1'b0);
		end
		repeat (8) @(negedge clk);
		chk("overrun", 8'(ovr_cnt - base), 8'h01);
		for (int i = 0; i < 3; i++) begin
			wait_rx();
			chk("drain", rx_data, bytes[i]);
			pop();
		end
		repeat (4) @(negedge clk);
		chk("drained", {7'h0, rx_holding_empty}, 8'h01);
	endtask

	task automatic t_shifter();
		@(posedge clk);
		select_mode_field <= 2'h0;
		tx_buf_empty <= 1'b0;
		tx_load <= 1'b1;
		@(posedge clk);
		tx_load <= 1'b0;
		tx_buf_empty <= 1'b1;
		repeat (3) @(negedge clk);
		chk("load clears", {7'h0, shifter_empty}, 8'h00);
		spc_link_model_inst.send_byte(8'hc3, 1'b0, 1'b0);
		wait_rx();
		chk("three-wire byte", rx_data, 8'hc3);
		repeat (3) @(negedge clk);
		chk("byte done", {7'h0, shifter_empty}, 8'h01);
		pop();
		select_mode_field <= 2'h1;
	endtask

	task automatic t_pins();
		logic [1:0] modes [3] = '{2'h2, 2'h3, 2'h0};
		logic [7:0] exp [3] = '{8'h00, 8'h02, 8'h03};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			select_mode_field <= modes[i];
			repeat (3) @(negedge clk);
			chk("select pin", {6'h0, sel_n_o | sel_n_oe_n, sel_n_oe_n}, exp[i]);
		end
		select_mode_field <= 2'h1;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(negedge clk);
		t_regs();
		t_select();
		t_modes();
		t_buffer();
		t_shifter();
		t_pins();
		finish_test();
	end

	initial begin
		#500000;
		n_mismatch++;
		finish_test();
	end
endmodule // tb
`default_nettype wire
